// ### hw/dpx_pkg.sv
// Shared constants and types for the DDR SDRAM pin interface.
// Assumes a 100 MHz system clock and a separate memory link clock.
package dpx_pkg;

  // ----------------------------------------------------------------
  // Widths and timing counts
  // ----------------------------------------------------------------
  localparam int         WORD_W    = 40;   // Data word plus check byte
  localparam int         BUF_DEPTH = 2;    // Read buffer entries
  localparam logic [2:0] RD_LAT    = 3'h3; // Link cycles, read issue to sample

  // ----------------------------------------------------------------
  // Pin patterns
  // ----------------------------------------------------------------
  localparam logic [1:0] CKE_ON  = 2'h3;
  localparam logic [1:0] CKE_OFF = 2'h0;
  localparam logic [1:0] CS_NONE = 2'h3;
  localparam logic [1:0] CS_R0   = 2'h2; // Select 0 low
  localparam logic [1:0] CS_R1   = 2'h1; // Select 1 low
  localparam logic [4:0] DQS_HI  = 5'h1F;
  // Row, column and write strobe levels, in that order
  localparam logic [2:0] RCW_NOP = 3'h7;
  localparam logic [2:0] RCW_ACT = 3'h3;
  localparam logic [2:0] RCW_RD  = 3'h5;
  localparam logic [2:0] RCW_WR  = 3'h4;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_MRS = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ACT = 4'h1, OP_RD  = 4'h2, OP_WR    = 4'h3,
    OP_PRE = 4'h4, OP_REF = 4'h5, OP_MRS = 4'h6, OP_SR_IN = 4'h7,
    OP_SR_OUT = 4'h8
  } dpx_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ISSUE = 3'h1, ST_WPRE = 3'h2,
    ST_WDAT = 3'h3, ST_RWAIT = 3'h4, ST_DONE = 3'h5
  } dpx_lst_e;

  // Command truth table: strobe levels for an operation
  function automatic logic [2:0] dpx_rcw(input dpx_op_e op);
    unique case (op)
      OP_ACT:   return RCW_ACT;
      OP_RD:    return RCW_RD;
      OP_WR:    return RCW_WR;
      OP_PRE:   return RCW_PRE;
      OP_REF:   return RCW_REF;
      OP_MRS:   return RCW_MRS;
      OP_SR_IN: return RCW_REF;
      default:  return RCW_NOP; // Undefined codes become no-operation
    endcase
  endfunction

endpackage

// ### hw/dpx_buf_if.sv
// Valid/ready link between the pin interface and its read buffer.
// Assumes both ends sit in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
interface dpx_buf_if;
  logic                       in_valid;
  logic                       in_ready;
  logic [dpx_pkg::WORD_W-1:0] in_data;
  logic                       out_valid;
  logic                       out_ready;
  logic [dpx_pkg::WORD_W-1:0] out_data;
  modport buf_side  (input in_valid, in_data, out_ready,
                     output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready,
                     input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ### hw/dpx_rd_buf.sv
// Two-entry read word buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dpx_rd_buf (
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  dpx_buf_if.buf_side bf
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [dpx_pkg::BUF_DEPTH-1:0][dpx_pkg::WORD_W-1:0] mem;
    logic                                               wp;
    logic                                               rp;
    logic [1:0]                                         cnt;
  } dpx_buf_s;

  dpx_buf_s q;
  dpx_buf_s d;
  logic     push;
  logic     pop;

  // Full and empty come straight from the count
  assign bf.in_ready  = (q.cnt != 2'(dpx_pkg::BUF_DEPTH));
  assign bf.out_valid = (q.cnt != 2'h0);
  assign bf.out_data  = q.mem[q.rp];
  assign push         = bf.in_valid && bf.in_ready;
  assign pop          = bf.out_valid && bf.out_ready;

  // Next state: write, read and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = bf.in_data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_buf_no_over : assert property (@(posedge sys_clk) disable iff (!rstn)
    (q.cnt == 2'h2 && !pop) |=> (q.cnt == 2'h2))
    else $error("read buffer count left full without a pop");

endmodule
`default_nettype wire

// ### hw/dpx_pin_top.sv
// DDR SDRAM pin interface: command port on the system clock, pins on
// the memory link clock. Assumes the link clock runs whenever power-on
// reset is released, and that two-way pins are resolved outside.
`timescale 1ns/1ps
`default_nettype none
module dpx_pin_top (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        por_n,
  input  wire logic        mem_link_clk,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [3:0]  cmd_op,
  input  wire logic        cmd_rank,
  input  wire logic [1:0]  cmd_bank,
  input  wire logic [13:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [7:0]  cmd_wecc,
  input  wire logic [4:0]  cmd_wmask,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [31:0]      rd_data,
  output logic [7:0]       rd_ecc,
  output logic [2:0]       mem_clk_pos,
  output logic [2:0]       mem_clk_neg,
  output logic             mem_clk_oe,
  output logic [1:0]       mem_clk_enable,
  output logic             mem_clk_enable_oe,
  output logic [1:0]       mem_bank_select_n,
  output logic             mem_row_strobe_n,
  output logic             mem_col_strobe_n,
  output logic             mem_write_strobe_n,
  output logic [4:0]       mem_byte_mask,
  output logic [1:0]       mem_internal_bank,
  output logic [13:0]      mem_mux_addr,
  output logic             mem_ctl_oe,
  input  wire logic [31:0] mem_data_bus_i,
  output logic [31:0]      mem_data_bus_o,
  output logic             mem_data_bus_oe,
  input  wire logic [7:0]  mem_check_byte_i,
  output logic [7:0]       mem_check_byte_o,
  output logic             mem_check_byte_oe,
  input  wire logic [4:0]  mem_data_strobe_i,
  output logic [4:0]       mem_data_strobe_o,
  output logic             mem_data_strobe_oe
);

  // ----------------------------------------------------------------
  // State of the system side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             busy;
    logic             req_tgl;
    dpx_pkg::dpx_op_e op;
    logic             rank;
    logic [1:0]       ba;
    logic [13:0]      addr;
    logic [31:0]      wdata;
    logic [7:0]       wecc;
    logic [4:0]       wmask;
    logic             d1;
    logic             d2;
    logic             d3;
  } dpx_sys_s;

  // ----------------------------------------------------------------
  // State of the link side
  // ----------------------------------------------------------------
  typedef struct packed {
    dpx_pkg::dpx_lst_e          st;
    logic                       run;
    logic [1:0]                 cke;
    logic                       r1;
    logic                       r2;
    logic                       r3;
    dpx_pkg::dpx_op_e           op;
    logic [2:0]                 cnt;
    logic [1:0]                 cs_n;
    logic [2:0]                 rcw;
    logic [1:0]                 ba;
    logic [13:0]                ma;
    logic [4:0]                 dm;
    logic                       ctl_oe;
    logic                       dq_oe;
    logic [31:0]                dq;
    logic [7:0]                 cb;
    logic [4:0]                 dqs;
    logic [dpx_pkg::WORD_W-1:0] in1;
    logic [dpx_pkg::WORD_W-1:0] in2;
    logic [dpx_pkg::WORD_W-1:0] rd_word;
    logic                       done_tgl;
  } dpx_link_s;

  dpx_sys_s  sq;
  dpx_sys_s  sd;
  dpx_link_s lq;
  dpx_link_s ld;
  logic [1:0] rst_sync_q;
  logic       lrst_n;
  logic       rst_all_n;
  logic       por_done_q;
  logic       take;
  logic       done_seen;
  dpx_buf_if  rb ();

  // ----------------------------------------------------------------
  // Link-side resets
  // ----------------------------------------------------------------
  // Either reset clears the link logic at once; release is synchronised
  assign rst_all_n = rstn & por_n;
  assign lrst_n    = rst_sync_q[1];

  always_ff @(posedge mem_link_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Clocks and clock enables float while power-on reset is held and until the first link clock edge after it lifts
  always_ff @(posedge mem_link_clk or negedge por_n) begin
    if (!por_n) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // System side: command capture and completion
  // ----------------------------------------------------------------
  // A read is taken only with buffer room, so its word can never be lost
  assign cmd_ready = !sq.busy && rb.in_ready;
  assign take      = cmd_valid && cmd_ready;
  assign done_seen = sq.busy && (sq.d2 != sq.d3);

  // Read word is held by the link side until the next read samples its own word
  assign rb.in_valid  = done_seen && (sq.op == dpx_pkg::OP_RD);
  assign rb.in_data   = lq.rd_word;
  assign rb.out_ready = rd_ready;
  assign rd_valid     = rb.out_valid;
  assign rd_data      = rb.out_data[31:0];
  assign rd_ecc       = rb.out_data[39:32];

  always_comb begin
    sd    = sq;
    sd.d1 = lq.done_tgl;
    sd.d2 = sq.d1;
    sd.d3 = sq.d2;
    if (done_seen) begin
      sd.busy = 1'b0;
    end
    // Fields stay frozen while busy, so the link may read them directly
    if (take) begin
      sd.busy    = 1'b1;
      sd.req_tgl = ~sq.req_tgl;
      sd.op      = dpx_pkg::dpx_op_e'(cmd_op);
      sd.rank    = cmd_rank;
      sd.ba      = cmd_bank;
      sd.addr    = cmd_addr;
      sd.wdata   = cmd_wdata;
      sd.wecc    = cmd_wecc;
      sd.wmask   = cmd_wmask;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  dpx_rd_buf u_rd_buf (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .bf      (rb)
  );

  // ----------------------------------------------------------------
  // Link side: command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    ld        = lq;
    ld.r1     = sq.req_tgl;
    ld.r2     = lq.r1;
    ld.r3     = lq.r2;
    ld.in1    = {mem_check_byte_i, mem_data_bus_i};
    ld.in2    = lq.in1;
    ld.run    = 1'b1;
    ld.ctl_oe = 1'b1;
    // Enables rise on the first cycle after reset and stay up in use
    if (!lq.run) begin
      ld.cke = dpx_pkg::CKE_ON;
    end
    unique case (lq.st)
      dpx_pkg::ST_IDLE: begin
        ld.cs_n = dpx_pkg::CS_NONE;
        ld.rcw  = dpx_pkg::RCW_NOP;
        if (lq.r2 != lq.r3) begin
          ld.op   = sq.op;
          ld.cs_n = sq.rank ? dpx_pkg::CS_R1 : dpx_pkg::CS_R0;
          ld.rcw  = dpx_pkg::dpx_rcw(sq.op);
          ld.ba   = sq.ba;
          ld.ma   = sq.addr;
          ld.st   = dpx_pkg::ST_ISSUE;
          if (sq.op == dpx_pkg::OP_SR_IN) begin
            ld.cke = dpx_pkg::CKE_OFF;
          end
          // Leaving self-refresh needs a deselect with enables back up
          if (sq.op == dpx_pkg::OP_SR_OUT) begin
            ld.cke  = dpx_pkg::CKE_ON;
            ld.cs_n = dpx_pkg::CS_NONE;
          end
        end
      end
      dpx_pkg::ST_ISSUE: begin
        ld.cs_n = dpx_pkg::CS_NONE;
        ld.rcw  = dpx_pkg::RCW_NOP;
        if (lq.op == dpx_pkg::OP_WR) begin
          // Preamble: strobes low while data, check byte and masks settle
          ld.dq_oe = 1'b1;
          ld.dq    = sq.wdata;
          ld.cb    = sq.wecc;
          ld.dm    = sq.wmask;
          ld.dqs   = 5'h0;
          ld.st    = dpx_pkg::ST_WPRE;
        end else if (lq.op == dpx_pkg::OP_RD) begin
          ld.cnt = dpx_pkg::RD_LAT;
          ld.st  = dpx_pkg::ST_RWAIT;
        end else begin
          ld.st = dpx_pkg::ST_DONE;
        end
      end
      dpx_pkg::ST_WPRE: begin
        ld.dqs = dpx_pkg::DQS_HI;
        ld.st  = dpx_pkg::ST_WDAT;
      end
      dpx_pkg::ST_WDAT: begin
        // Release the bus so the memory may drive it on the next read
        ld.dq_oe = 1'b0;
        ld.dqs   = 5'h0;
        ld.dm    = 5'h0;
        ld.st    = dpx_pkg::ST_DONE;
      end
      dpx_pkg::ST_RWAIT: begin
        // Fixed latency; the input path adds its two sampling flops
        if (lq.cnt == 3'h0) begin
          ld.rd_word = lq.in2;
          ld.st      = dpx_pkg::ST_DONE;
        end else begin
          ld.cnt = 3'(lq.cnt - 3'h1);
        end
      end
      dpx_pkg::ST_DONE: begin
        ld.done_tgl = ~lq.done_tgl;
        ld.st       = dpx_pkg::ST_IDLE;
      end
      default: begin
        ld.st = dpx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mem_link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lq     <= '0;
      lq.st  <= dpx_pkg::ST_IDLE;
      lq.cke <= dpx_pkg::CKE_OFF;
      lq.rcw <= dpx_pkg::RCW_NOP;
      lq.cs_n <= dpx_pkg::CS_NONE;
    end else begin
      lq <= ld;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Forwarded clock pair; stopped low/high until the link leaves reset
  assign mem_clk_pos        = lq.run ? {3{mem_link_clk}} : 3'h0;
  assign mem_clk_neg        = ~mem_clk_pos;
  assign mem_clk_oe         = por_done_q;
  assign mem_clk_enable     = lq.cke;
  assign mem_clk_enable_oe  = por_done_q;
  assign mem_bank_select_n  = lq.cs_n;
  assign mem_row_strobe_n   = lq.rcw[2];
  assign mem_col_strobe_n   = lq.rcw[1];
  assign mem_write_strobe_n = lq.rcw[0];
  assign mem_byte_mask      = lq.dm;
  assign mem_internal_bank  = lq.ba;
  assign mem_mux_addr       = lq.ma;
  assign mem_ctl_oe         = lq.ctl_oe;
  assign mem_data_bus_o     = lq.dq;
  assign mem_data_bus_oe    = lq.dq_oe;
  assign mem_check_byte_o   = lq.cb;
  assign mem_check_byte_oe  = lq.dq_oe;
  assign mem_data_strobe_o  = lq.dqs;
  assign mem_data_strobe_oe = lq.dq_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Under rstn with power-on reset already lifted: clock pair stopped but driven, clock enables low
  a_clk_reset_lvl : assert property (@(posedge mem_link_clk) disable iff (!por_n)
    (!rstn && $past(por_n)) |-> (!lq.run && mem_clk_oe && mem_clk_enable == dpx_pkg::CKE_OFF))
    else $error("clock pair or enables wrong during reset");

  a_ctl_float : assert property (@(posedge mem_link_clk) disable iff (!por_n)
    !rstn |-> (!mem_ctl_oe && !mem_data_bus_oe && !mem_data_strobe_oe))
    else $error("control or data pins driven during reset");

  a_ctl_driven : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    $past(lrst_n) |-> mem_ctl_oe)
    else $error("control pins not driven after reset");

  a_act_row : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    (lq.st == dpx_pkg::ST_ISSUE && lq.op == dpx_pkg::OP_ACT) |->
      (!mem_row_strobe_n && mem_col_strobe_n && mem_write_strobe_n
       && mem_mux_addr == sq.addr && mem_internal_bank == sq.ba))
    else $error("activate did not show a row address");

  a_rd_column : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    (lq.st == dpx_pkg::ST_ISSUE && lq.op == dpx_pkg::OP_RD) |->
      (mem_row_strobe_n && !mem_col_strobe_n && mem_write_strobe_n)
      ##1 (mem_row_strobe_n && mem_col_strobe_n && !mem_data_bus_oe))
    else $error("read did not show a column address");

  a_cs_select : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    (lq.st == dpx_pkg::ST_ISSUE && lq.op != dpx_pkg::OP_SR_OUT) |->
      (mem_bank_select_n == (sq.rank ? 2'h1 : 2'h2)))
    else $error("addressed select not asserted for a command");

  a_wr_data : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    (lq.st == dpx_pkg::ST_ISSUE && lq.op == dpx_pkg::OP_WR) |->
      !mem_write_strobe_n
      ##1 (mem_data_bus_oe && mem_data_strobe_o == 5'h00 && mem_byte_mask == sq.wmask)
      ##1 (mem_data_strobe_o == 5'h1F && mem_data_bus_o == sq.wdata
           && mem_check_byte_o == sq.wecc)
      ##1 !mem_data_bus_oe)
    else $error("write data, mask or strobes out of step");

  a_strobe_data : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    mem_data_strobe_oe |-> (mem_data_bus_oe && mem_check_byte_oe))
    else $error("strobes driven without their data");

  a_sref_cke : assert property (@(posedge mem_link_clk) disable iff (!lrst_n)
    (lq.st == dpx_pkg::ST_ISSUE && lq.op == dpx_pkg::OP_SR_IN) |->
      (mem_clk_enable == 2'h0 && !mem_row_strobe_n && !mem_col_strobe_n)
      ##1 (mem_clk_enable == 2'h0)[*2])
    else $error("self-refresh entry did not drop the enables");

  a_read_return : assert property (@(posedge sys_clk) disable iff (!rstn)
    (take && cmd_op == 4'h2) |-> ##[4:40] rb.in_valid)
    else $error("read word did not reach the buffer in time");

endmodule
`default_nettype wire

// ### sim/dpx_mem_model.sv
// Behavioural DDR memory standing on the pin side of the interface.
// Assumes one-beat writes and a read answered over eight link cycles.
`timescale 1ns/1ps
`default_nettype none
module dpx_mem_model (
  input  wire logic        clk,
  input  wire logic [1:0]  cs_n,
  input  wire logic [2:0]  rcw,
  input  wire logic [13:0] addr,
  input  wire logic [4:0]  mask,
  input  wire logic [39:0] wword,
  input  wire logic        oe,
  input  wire logic [4:0]  dqs_o,
  output logic      [39:0] rword,
  output logic      [4:0]  dqs_i
);
  // ----------------------------------------------------------------
  // Storage and read answer
  // ----------------------------------------------------------------
  logic [39:0] mem [logic [13:0]];
  logic [39:0] tmp;
  logic [13:0] wa_q;
  logic [39:0] last_q = 40'h0;
  logic [3:0]  cnt_q  = 4'h0;
  // Resolved lines; once our hold runs out we drive junk, not the word
  assign rword = oe ? wword : (cnt_q != 4'h0 ? last_q : ~last_q);
  assign dqs_i = oe ? dqs_o : {5{cnt_q[0]}};
  // Commands seen on the link edge; masked bytes keep old contents
  always @(posedge clk) begin
    if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    if (cs_n != 2'h3 && rcw == dpx_pkg::RCW_WR) wa_q <= addr;
    if (cs_n != 2'h3 && rcw == dpx_pkg::RCW_RD) begin
      last_q <= mem.exists(addr) ? mem[addr] : 40'h0;
      cnt_q  <= 4'h8;
    end
    if (oe && dqs_o == dpx_pkg::DQS_HI) begin
      tmp = mem.exists(wa_q) ? mem[wa_q] : 40'h0;
      for (int b = 0; b < 5; b++) if (!mask[b]) tmp[8*b +: 8] = wword[8*b +: 8];
      mem[wa_q] = tmp;
    end
  end
endmodule
`default_nettype wire

// ### sim/ddr_sdram_pin_interface_tb.sv
// Self-checking bench for the DDR pin interface with a memory model.
// Assumes the design package and read buffer are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_pin_interface_tb;
  // ----------------------------------------------------------------
  // Stimulus, pins and captures
  // ----------------------------------------------------------------
  logic        sys_clk = 0, link_clk = 0, rstn = 0, por_n = 0;
  logic        cmd_valid = 0, cmd_rank = 0, rd_ready = 0;
  logic [3:0]  cmd_op = 0;
  logic [1:0]  cmd_bank = 0;
  logic [13:0] cmd_addr = 0;
  logic [39:0] cmd_w = 0;
  logic [4:0]  cmd_m = 0;
  logic        cmd_ready, rd_valid, clk_oe, cke_oe, ras, cas, we, ctl_oe, dq_oe, cb_oe, dqs_oe;
  logic [31:0] rd_data, dq_o;
  logic [7:0]  rd_ecc, cb_o;
  logic [2:0]  ck_p, ck_n;
  logic [1:0]  cke, cs_n, ba, c_cs, c_ba;
  logic [4:0]  dm, dqs_o, c_dm;
  logic [13:0] ma, c_ma;
  logic [2:0]  c_rcw;
  logic [39:0] c_word;
  wire  [39:0] rw;
  wire  [4:0]  dqs_i;
  int          error_cnt = 0, samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  // Link clock unrelated in phase to the system clock
  initial begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  dpx_pin_top dpx_pin_top_i (.sys_clk(sys_clk), .rstn(rstn), .por_n(por_n),
    .mem_link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_rank(cmd_rank), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_wdata(cmd_w[31:0]),
    .cmd_wecc(cmd_w[39:32]), .cmd_wmask(cmd_m), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .rd_ecc(rd_ecc), .mem_clk_pos(ck_p), .mem_clk_neg(ck_n),
    .mem_clk_oe(clk_oe), .mem_clk_enable(cke), .mem_clk_enable_oe(cke_oe),
    .mem_bank_select_n(cs_n), .mem_row_strobe_n(ras), .mem_col_strobe_n(cas),
    .mem_write_strobe_n(we), .mem_byte_mask(dm), .mem_internal_bank(ba), .mem_mux_addr(ma),
    .mem_ctl_oe(ctl_oe), .mem_data_bus_i(rw[31:0]), .mem_data_bus_o(dq_o),
    .mem_data_bus_oe(dq_oe), .mem_check_byte_i(rw[39:32]), .mem_check_byte_o(cb_o),
    .mem_check_byte_oe(cb_oe), .mem_data_strobe_i(dqs_i), .mem_data_strobe_o(dqs_o),
    .mem_data_strobe_oe(dqs_oe));
  dpx_mem_model dpx_mem_model_i (.clk(link_clk), .cs_n(cs_n), .rcw({ras, cas, we}), .addr(ma),
    .mask(dm), .wword({cb_o, dq_o}), .oe(dq_oe), .dqs_o(dqs_o), .rword(rw), .dqs_i(dqs_i));
  // Pin monitor: last selected command and last write beat
  always @(posedge link_clk) begin
    if (ctl_oe && cs_n != 2'h3) begin
      c_cs  <= cs_n;
      c_rcw <= {ras, cas, we};
      c_ba  <= ba;
      c_ma  <= ma;
    end
    if (dqs_oe && dqs_o == dpx_pkg::DQS_HI) begin
      c_word <= {cb_o, dq_o};
      c_dm   <= dm;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until a negedge sees ready, so the next rising edge takes it
  task automatic cmd(input logic [3:0] op, input logic rk, input logic [13:0] a,
                     input logic [39:0] w, input logic [4:0] m);
    int n;
    n = 0;
    @(negedge sys_clk);
    {cmd_valid, cmd_op, cmd_rank, cmd_bank, cmd_addr, cmd_w, cmd_m} = {1'b1, op, rk, 2'h2, a, w, m};
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk("cmd taken", 1, cmd_ready);
    @(negedge sys_clk);
    cmd_valid = 0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk("cmd_ready", 1, cmd_ready);
  endtask
  task automatic pop(input logic [39:0] exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (rd_valid !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rd_word", exp, {rd_ecc, rd_data});
    rd_ready = 1;
    @(negedge sys_clk);
    rd_ready = 0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (5) @(negedge sys_clk);
    chk("por oe", 5'h0, {clk_oe, cke_oe, ctl_oe, dq_oe, dqs_oe});
    por_n = 1;
    repeat (15) @(negedge sys_clk);
    chk("rst clocks", {3'h0, 3'h7, 1'b1}, {ck_p, ck_n, clk_oe});
    chk("rst cke", 3'h1, {cke, cke_oe});
    chk("rst ctl oe", 0, ctl_oe);
    rstn = 1;
    repeat (10) @(negedge sys_clk);
    chk("idle pins", {1'b1, 2'h3, 3'h7, 2'h3}, {ctl_oe, cs_n, ras, cas, we, cke});
    chk("clk pair", {~ck_p}, ck_n);
    $display("test reset done");
  endtask
  task automatic t_wr_rd();
    cmd(4'h3, 0, 14'h3A5C, 40'hA512345678, 5'h00);
    wait_idle();
    chk("wr cmd", {dpx_pkg::CS_R0, dpx_pkg::RCW_WR, 2'h2, 14'h3A5C}, {c_cs, c_rcw, c_ba, c_ma});
    chk("wr beat", 40'hA512345678, c_word);
    chk("wr beat mask", 5'h00, c_dm);
    cmd(4'h3, 0, 14'h3A5C, 40'h5ACAFEF00D, 5'h12);
    wait_idle();
    chk("wr mask", 5'h12, c_dm);
    cmd(4'h2, 1, 14'h3A5C, 40'h0, 5'h00);
    wait_idle();
    chk("rd cmd", {dpx_pkg::CS_R1, dpx_pkg::RCW_RD}, {c_cs, c_rcw});
    pop(40'hA5CAFE560D);
    $display("test write read done");
  endtask
  task automatic t_cmds();
    logic [3:0] ops [4] = '{4'h1, 4'h4, 4'h5, 4'h6};
    logic [2:0] exp [4] = '{dpx_pkg::RCW_ACT, dpx_pkg::RCW_PRE, dpx_pkg::RCW_REF, dpx_pkg::RCW_MRS};
    for (int i = 0; i < 4; i++) begin
      cmd(ops[i], i[0], 14'h0100 + 14'(i), 40'h0, 5'h00);
      wait_idle();
      chk("cmd pins", {i[0] ? dpx_pkg::CS_R1 : dpx_pkg::CS_R0, exp[i], 14'h0100 + 14'(i)},
          {c_cs, c_rcw, c_ma});
    end
    $display("test command table done");
  endtask
  task automatic t_buf();
    cmd(4'h2, 0, 14'h3A5C, 40'h0, 5'h00);
    wait_idle();
    cmd(4'h2, 0, 14'h3A5C, 40'h0, 5'h00);
    repeat (60) @(negedge sys_clk);
    chk("full refuses", 0, cmd_ready);
    pop(40'hA5CAFE560D);
    pop(40'hA5CAFE560D);
    wait_idle();
    $display("test buffer done");
  endtask
  task automatic t_sref();
    cmd(4'h7, 0, 14'h0, 40'h0, 5'h00);
    wait_idle();
    repeat (4) @(negedge sys_clk);
    chk("sref cke", 2'h0, cke);
    cmd(4'h8, 0, 14'h0, 40'h0, 5'h00);
    wait_idle();
    repeat (4) @(negedge sys_clk);
    chk("run cke", 2'h3, cke);
    $display("test self refresh done");
  endtask
  // Second reset in mid-run: pins must fall back to their reset levels
  task automatic t_mid_reset();
    @(negedge sys_clk);
    rstn = 0;
    repeat (5) @(negedge sys_clk);
    chk("mid rst pins", {3'h0, 1'b1, 2'h0, 1'b1, 3'h0},
        {ck_p, clk_oe, cke, cke_oe, ctl_oe, dq_oe, cb_oe});
    rstn = 1;
    repeat (10) @(negedge sys_clk);
    chk("mid rel pins", {1'b1, 2'h3, 3'h7, 2'h3, 1'b1},
        {ctl_oe, cs_n, ras, cas, we, cke, cmd_ready});
    $display("test mid reset done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; the watchdog allows 30000, about a hundred times that
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    t_reset();
    t_wr_rd();
    t_cmds();
    t_buf();
    t_sref();
    t_mid_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
